/* inc/async_serial_transceiver_consts.svh */
// Purpose: constants for the asynchronous serial transceiver
// Assumes: 125 MHz sys_clk
// Notes: offsets none; counts, a prescaler code and reset values only
`ifndef ASYNC_SERIAL_TRANSCEIVER_CONSTS_SVH
`define ASYNC_SERIAL_TRANSCEIVER_CONSTS_SVH
`define OVERSAMPLE 5'd16
`define START_WAIT 4'd7
`define AUTO_SAMPLE_POS 4'd7
`define PSC_OFF 5'h00
`define DATA_W 8
`define IDLE_LEVEL 1'b1
`endif

/* inc/async_serial_pkg.sv */
// Purpose: types for the asynchronous serial transceiver
// Assumes: nothing
// Notes: one-hot state codes
package async_serial_pkg;
  typedef enum logic [1:0] {
    LEN_7 = 2'h0,
    LEN_8 = 2'h1,
    LEN_9 = 2'h2
  } data_len_t;
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_EVEN = 2'h1,
    PAR_ODD = 2'h2
  } parity_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_BITS = 4'h4,
    TX_STOP = 4'h8
  } tx_state_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_BITS = 4'h4,
    RX_STOP = 4'h8
  } rx_state_t;
endpackage : async_serial_pkg

/* rtl/async_serial_transceiver.sv */
// Purpose: full-duplex double-buffered asynchronous serial transceiver
// Assumes: one clock, pins synchronised inside, sysclk 125 MHz
// Notes: control and status bits are plain ports
//
// Overview of operation
// - tx holding buffer loads shifter; shifter sends LSB first on txPin
// - after last stop bit, oldest buffer entry moves to shifter; empty flag sets if none remains
// - software write to tx holding buffer clears empty flag
// - in-progress flag high until last stop sent and buffer empty
// - tx holding buffer readable and writable; shifter hidden
// - receiver oversamples at sixteen ticks per bit
// - internal baud generator always clocks asynchronous operation
// - after low, wait seven ticks; three low samples confirm start
// - each later bit sampled three times, majority decides
// - sample position automatic unless override bit selects programmed one
// - rx shifter copies into rx holding buffer after full character
// - copy into rx holding buffer sets full flag
// - software read of rx holding buffer clears full flag
// - baud chain: prescaler then divisor forms oversample tick, sixteen per bit
// - deasserted cts pauses transmit after current frame
// - rts asserted when ready to send a character
// - 7, 8 or 9 data bits, even/odd/none parity with 7 or 8 bits, one/two stops
// - parity generated and checked; parity, framing, overrun flagged
// - software break transmit; break detected on receive
// - tx-ready and rx-ready interrupts with separate enables
// - flow control only on first instance; parameter selects
// - ninth bit carried both ways
// - 5-bit prescaler select and 11-bit divisor
// - prescaler code zero stops the serial clock
`timescale 1ns/100ps
`include "async_serial_transceiver_consts.svh"
module async_serial_transceiver #(
  parameter bit FIRST_INSTANCE = 1'b1,
  parameter int DIV_W = 11
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic txWrite,
  input wire logic [7:0] txWriteData,
  input wire logic txNinth,
  output logic txWriteReady,
  output logic [7:0] txHoldRead,
  input wire logic rxRead,
  output logic [7:0] rxData,
  output logic rxNinth,
  output logic rxValid,
  input wire async_serial_pkg::data_len_t dataLen,
  input wire async_serial_pkg::parity_t parityMode,
  input wire logic twoStop,
  input wire logic sendBreak,
  input wire logic [4:0] baudPrescalerSelect,
  input wire logic [DIV_W-1:0] baudDivisor,
  input wire logic sampleOverrideBit,
  input wire logic [3:0] samplePositionReg,
  input wire logic txIntEnable,
  input wire logic rxIntEnable,
  input wire logic flowEnable,
  input wire logic rxPin,
  input wire logic ctsPinN,
  output logic txPin,
  output logic rtsPinN,
  output logic txBufferEmptyFlag,
  output logic txInProgressFlag,
  output logic rxBufferFullFlag,
  output logic parityError,
  output logic framingError,
  output logic overrunError,
  output logic breakDetect,
  output logic txIrq,
  output logic rxIrq
);
  import async_serial_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rxSync_q;
  logic [1:0] ctsSync_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxSync_q <= 2'h3;
      ctsSync_q <= 2'h3;
    end else begin
      rxSync_q <= {rxSync_q[0], rxPin};
      ctsSync_q <= {ctsSync_q[0], ctsPinN};
    end
  end
  wire logic rxIn = rxSync_q[1];
  wire logic ctsOk = !(FIRST_INSTANCE && flowEnable) || !ctsSync_q[1];

  // ------------------------------------------------------------
  // baud generator
  // ------------------------------------------------------------
  // prescaler counts half cycles: factor = code/2 + 0.5
  logic [5:0] pscAcc_q;
  logic pscTick;
  logic [DIV_W-1:0] divCnt_q;
  logic tick_q;
  wire logic [5:0] pscStep = {1'b0, baudPrescalerSelect} + 6'h01;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pscAcc_q <= 6'h00;
    end else if (baudPrescalerSelect == `PSC_OFF) begin
      pscAcc_q <= 6'h00;
    end else if (pscAcc_q + 6'h02 >= pscStep) begin
      pscAcc_q <= pscAcc_q + 6'h02 - pscStep;
    end else begin
      pscAcc_q <= pscAcc_q + 6'h02;
    end
  end
  assign pscTick = (baudPrescalerSelect != `PSC_OFF) &&
                   (pscAcc_q + 6'h02 >= pscStep);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (baudPrescalerSelect == `PSC_OFF) begin
        divCnt_q <= '0;
      end else if (pscTick) begin
        if (divCnt_q >= baudDivisor) begin
          divCnt_q <= '0;
          tick_q <= 1'b1;
        end else begin
          divCnt_q <= divCnt_q + 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // frame helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] dataBits(input data_len_t len);
    unique case (len)
      LEN_7: dataBits = 4'd7;
      LEN_9: dataBits = 4'd9;
      default: dataBits = 4'd8;
    endcase
  endfunction : dataBits
  // total bits after start: data + parity (not in 9-bit) + stops
  function automatic logic [3:0] bodyBits(input data_len_t len,
                                          input parity_t par,
                                          input logic two);
    logic usePar;
    usePar = (par != PAR_NONE) && (len != LEN_9);
    bodyBits = dataBits(len) + {3'h0, usePar} + {3'h0, two} + 4'd1;
  endfunction : bodyBits
  wire logic usePar = (parityMode != PAR_NONE) && (dataLen != LEN_9);

  // ------------------------------------------------------------
  // two-entry transmit buffer
  // ------------------------------------------------------------
  logic [8:0] txFifo_q [2];
  logic txWp_q;
  logic txRp_q;
  logic [1:0] txCnt_q;
  logic txPop;
  wire logic txPush = txWrite && txCnt_q != 2'd2;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txWp_q <= 1'b0;
      txRp_q <= 1'b0;
      txCnt_q <= 2'd0;
    end else begin
      if (txPush) begin
        txWp_q <= ~txWp_q;
      end
      if (txPop) begin
        txRp_q <= ~txRp_q;
      end
      txCnt_q <= txCnt_q + {1'b0, txPush} - {1'b0, txPop};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (txPush) begin
      txFifo_q[txWp_q] <= {txNinth, txWriteData};
    end
  end

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  tx_state_t txState_q;
  logic [8:0] txShift_q;
  logic [3:0] txOs_q;
  logic [3:0] txBit_q;
  logic txPar_q;
  wire logic txHas = txCnt_q != 2'd0;
  assign txPop = (txState_q == TX_IDLE) && txHas && ctsOk;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txState_q <= TX_IDLE;
      txShift_q <= '0;
      txOs_q <= 4'h0;
      txBit_q <= 4'h0;
      txPar_q <= 1'b0;
      txPin <= `IDLE_LEVEL;
    end else begin
      unique case (txState_q)
        TX_IDLE: begin
          txPin <= !sendBreak;
          if (txPop) begin
            txShift_q <= txFifo_q[txRp_q];
            txPar_q <= (parityMode == PAR_ODD);
            txOs_q <= 4'h0;
            txState_q <= TX_START;
          end
        end
        TX_START: begin
          txPin <= 1'b0;
          if (tick_q) begin
            txOs_q <= txOs_q + 4'h1;
            if (txOs_q == 4'hf) begin
              txBit_q <= 4'h0;
              txState_q <= TX_BITS;
            end
          end
        end
        TX_BITS: begin
          if (txBit_q < dataBits(dataLen)) begin
            txPin <= txShift_q[0] && !sendBreak;
          end else if (usePar && txBit_q == dataBits(dataLen)) begin
            txPin <= txPar_q && !sendBreak;
          end else begin
            txPin <= !sendBreak;
          end
          if (tick_q) begin
            txOs_q <= txOs_q + 4'h1;
            if (txOs_q == 4'hf) begin
              txBit_q <= txBit_q + 4'h1;
              if (txBit_q < dataBits(dataLen)) begin
                txPar_q <= txPar_q ^ txShift_q[0];
                txShift_q <= {1'b0, txShift_q[8:1]};
              end
              if (txBit_q + 4'h1 ==
                  bodyBits(dataLen, parityMode, twoStop)) begin
                txState_q <= TX_IDLE;
              end
            end
          end
        end
        default: begin
          txState_q <= TX_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // transmit status
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txBufferEmptyFlag <= 1'b1;
      txInProgressFlag <= 1'b0;
      txWriteReady <= 1'b1;
      txHoldRead <= 8'h00;
      rtsPinN <= 1'b1;
      txIrq <= 1'b0;
    end else begin
      txBufferEmptyFlag <= (txCnt_q + {1'b0, txPush} - {1'b0, txPop})
                           == 2'd0;
      txInProgressFlag <= txHas || txPush ||
                          (txState_q != TX_IDLE);
      txWriteReady <= !((txCnt_q == 2'd2) ||
                        (txCnt_q == 2'd1 && txPush && !txPop));
      if (txPush) begin
        txHoldRead <= txWriteData;
      end
      rtsPinN <= !(FIRST_INSTANCE && txHas);
      txIrq <= txIntEnable && txBufferEmptyFlag;
    end
  end

  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  rx_state_t rxState_q;
  logic [8:0] rxShift_q;
  logic [3:0] rxOs_q;
  logic [3:0] rxBit_q;
  logic [2:0] rxSmp_q;
  logic rxPar_q;
  logic rxAllZero_q;
  logic rxDone;
  wire logic [3:0] smpPos = sampleOverrideBit ? samplePositionReg
                                              : `AUTO_SAMPLE_POS;
  wire logic vote = (rxSmp_q[0] & rxSmp_q[1]) | (rxSmp_q[1] & rxSmp_q[2]) |
                    (rxSmp_q[0] & rxSmp_q[2]);
  wire logic [3:0] rxBody = bodyBits(dataLen, parityMode, 1'b0);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxState_q <= RX_IDLE;
      rxShift_q <= '0;
      rxOs_q <= 4'h0;
      rxBit_q <= 4'h0;
      rxSmp_q <= 3'h7;
      rxPar_q <= 1'b0;
      rxAllZero_q <= 1'b1;
    end else begin
      unique case (rxState_q)
        RX_IDLE: begin
          if (tick_q && !rxIn) begin
            rxOs_q <= 4'h0;
            rxState_q <= RX_START;
          end
        end
        RX_START: begin
          if (tick_q) begin
            rxOs_q <= rxOs_q + 4'h1;
            if (rxOs_q >= `START_WAIT && rxOs_q < `START_WAIT + 4'd3) begin
              if (rxIn) begin
                rxState_q <= RX_IDLE;
              end
            end
            if (rxOs_q == 4'hf) begin
              rxBit_q <= 4'h0;
              rxPar_q <= (parityMode == PAR_ODD);
              rxAllZero_q <= 1'b1;
              rxState_q <= RX_BITS;
            end
          end
        end
        RX_BITS: begin
          if (tick_q) begin
            rxOs_q <= rxOs_q + 4'h1;
            if (rxOs_q >= smpPos - 4'd1 && rxOs_q <= smpPos + 4'd1) begin
              rxSmp_q <= {rxSmp_q[1:0], rxIn};
            end
            if (rxOs_q == 4'hf) begin
              rxBit_q <= rxBit_q + 4'h1;
              rxAllZero_q <= rxAllZero_q && !vote;
              if (rxBit_q < dataBits(dataLen)) begin
                rxShift_q <= {vote, rxShift_q[8:1]};
                rxPar_q <= rxPar_q ^ vote;
              end
              if (rxBit_q + 4'h1 == rxBody) begin
                rxState_q <= RX_IDLE;
              end
            end
          end
        end
        default: begin
          rxState_q <= RX_IDLE;
        end
      endcase
    end
  end
  assign rxDone = (rxState_q == RX_BITS) && tick_q && rxOs_q == 4'hf &&
                  (rxBit_q + 4'h1 == rxBody);

  // ------------------------------------------------------------
  // receive buffer and errors
  // ------------------------------------------------------------
  // align shifted data to bit 0 for 7 and 8 bit frames
  wire logic [8:0] rxAligned = (dataLen == LEN_7) ? {2'h0, rxShift_q[8:2]} :
                               (dataLen == LEN_8) ? {1'b0, rxShift_q[8:1]} :
                                                    rxShift_q;
  wire logic parBad = usePar && rxBit_q == dataBits(dataLen) ?
                      (rxPar_q ^ vote) : 1'b0;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxData <= 8'h00;
      rxNinth <= 1'b0;
      rxValid <= 1'b0;
      rxBufferFullFlag <= 1'b0;
      parityError <= 1'b0;
      framingError <= 1'b0;
      overrunError <= 1'b0;
      breakDetect <= 1'b0;
      rxIrq <= 1'b0;
    end else begin
      if (rxDone) begin
        rxData <= rxAligned[7:0];
        rxNinth <= rxAligned[8];
        rxBufferFullFlag <= 1'b1;
        rxValid <= 1'b1;
        overrunError <= rxBufferFullFlag && !rxRead;
        framingError <= !vote;
        parityError <= usePar && parityError;
        breakDetect <= rxAllZero_q && !vote;
      end else if (rxRead) begin
        rxBufferFullFlag <= 1'b0;
        rxValid <= 1'b0;
      end
      if (rxState_q == RX_BITS && tick_q && rxOs_q == 4'hf &&
          usePar && rxBit_q == dataBits(dataLen)) begin
        parityError <= parBad;
      end
      rxIrq <= rxIntEnable && rxBufferFullFlag;
    end
  end
endmodule : async_serial_transceiver

/* tb/async_serial_transceiver_asserts.sv */
// Purpose: port assertions for the serial transceiver
// Assumes: one clock domain, async active-low reset
// Notes: bound into every transceiver instance
`timescale 1ns/100ps
module async_serial_transceiver_asserts (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic txWrite,
  input wire logic txWriteReady,
  input wire logic rxRead,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic sendBreak,
  input wire logic txIntEnable,
  input wire logic rxIntEnable,
  input wire logic flowEnable,
  input wire logic txPin,
  input wire logic rtsPinN,
  input wire logic txBufferEmptyFlag,
  input wire logic txInProgressFlag,
  input wire logic rxBufferFullFlag,
  input wire logic txIrq,
  input wire logic rxIrq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_write;
    txWrite && txWriteReady;
  endsequence
  sequence s_break_held;
    sendBreak [*3];
  endsequence
  a_empty_clear: assert property (s_write |=> !txBufferEmptyFlag)
    else $error("empty flag still set after write");
  a_full_ready: assert property (!txWriteReady |-> !txBufferEmptyFlag)
    else $error("buffer refuses writes while empty");
  a_idle_high: assert property (!txInProgressFlag && !sendBreak
      && !$past(sendBreak) && !$past(sendBreak, 2) |-> txPin)
    else $error("line low while idle");
  a_start_low: assert property ($rose(txInProgressFlag) && !flowEnable
      && !sendBreak |-> ##[0:3] !txPin)
    else $error("no start bit after load");
  a_idle_empty: assert property (!txInProgressFlag && !flowEnable
      |-> txBufferEmptyFlag)
    else $error("idle while data held");
  a_break_low: assert property (s_break_held |-> !txPin)
    else $error("break not driven");
  a_tx_irq: assert property ($past(rstn) |->
      txIrq == ($past(txIntEnable) && $past(txBufferEmptyFlag)))
    else $error("tx interrupt mismatch");
  a_rx_irq: assert property ($past(rstn) |->
      rxIrq == ($past(rxIntEnable) && $past(rxBufferFullFlag)))
    else $error("rx interrupt mismatch");
  a_rx_valid: assert property (rxValid == rxBufferFullFlag)
    else $error("valid differs from full flag");
  a_rx_clear: assert property (rxRead && rxBufferFullFlag |=>
      !rxBufferFullFlag || $changed(rxData))
    else $error("full flag kept after read");
  a_rts_low: assert property ($fell(txBufferEmptyFlag)
      |-> ##[0:2] !rtsPinN)
    else $error("rts not asserted with data");
endmodule : async_serial_transceiver_asserts
bind async_serial_transceiver async_serial_transceiver_asserts chk_inst (
  .sys_clk, .rstn, .txWrite, .txWriteReady, .rxRead, .rxData, .rxValid,
  .sendBreak, .txIntEnable, .rxIntEnable, .flowEnable, .txPin, .rtsPinN,
  .txBufferEmptyFlag, .txInProgressFlag, .rxBufferFullFlag, .txIrq, .rxIrq
);

/* tb/serial_peer_model.sv */
// Purpose: remote serial device on the far side of the line
// Assumes: bitClks clocks per bit, set by the bench
// Notes: samples each bit at its middle
`timescale 1ns/100ps
module serial_peer_model (
  input wire logic sys_clk,
  input wire logic lineIn,
  input wire logic [7:0] bitClks,
  output logic lineOut,
  output logic ctsPinN
);
  initial begin
    lineOut = 1'b1;
    ctsPinN = 1'b0;
  end
  task automatic set_cts(input logic stop);
    @(posedge sys_clk);
    ctsPinN <= stop;
  endtask : set_cts
  task automatic recv(input int n, output logic [9:0] bits,
                      output logic stopOk);
    bits = '0;
    @(negedge lineIn);
    repeat (bitClks / 2) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      repeat (bitClks) @(posedge sys_clk);
      bits[i] = lineIn;
    end
    repeat (bitClks) @(posedge sys_clk);
    stopOk = lineIn;
  endtask : recv
  task automatic send(input logic [9:0] bits, input int n,
                      input logic stopLvl, input int stops);
    @(posedge sys_clk);
    for (int i = -1; i < n + stops; i++) begin
      lineOut <= (i < 0) ? 1'b0 : (i < n) ? bits[i] : stopLvl;
      repeat (bitClks) @(posedge sys_clk);
    end
    lineOut <= 1'b1;
  endtask : send
endmodule : serial_peer_model

/* tb/test_async_serial_transceiver.sv */
// Purpose: self-checking bench for the serial transceiver
// Assumes: 16 ticks per bit, tick from prescaler and divisor
// Notes: random data from a fixed xorshift seed
`timescale 1ns/100ps
module test_async_serial_transceiver;
  import async_serial_pkg::*;
  logic sys_clk, rstn, txWrite, txNinth, rxRead, twoStop, sendBreak;
  logic sampleOverrideBit, txIntEnable, rxIntEnable, flowEnable;
  logic txWriteReady, rxNinth, rxValid, rxPin, ctsPinN, txPin, rtsPinN;
  logic txBufferEmptyFlag, txInProgressFlag, rxBufferFullFlag, ok0, ok1;
  logic parityError, framingError, overrunError, breakDetect, txIrq, rxIrq;
  logic [7:0] txWriteData, txHoldRead, rxData, bitClks;
  logic [4:0] baudPrescalerSelect;
  logic [10:0] baudDivisor;
  logic [3:0] samplePositionReg;
  logic [31:0] seed, r;
  logic [9:0] b0, b1, f0;
  logic pe, fe;
  data_len_t dataLen, l;
  parity_t parityMode, p;
  int fails, samples_checked, n;
  async_serial_transceiver #(.FIRST_INSTANCE(1'b1), .DIV_W(11))
    async_serial_transceiver_inst (
    .sys_clk, .rstn, .txWrite, .txWriteData, .txNinth, .txWriteReady,
    .txHoldRead, .rxRead, .rxData, .rxNinth, .rxValid, .dataLen,
    .parityMode, .twoStop, .sendBreak, .baudPrescalerSelect, .baudDivisor,
    .sampleOverrideBit, .samplePositionReg, .txIntEnable, .rxIntEnable,
    .flowEnable, .rxPin, .ctsPinN, .txPin, .rtsPinN, .txBufferEmptyFlag,
    .txInProgressFlag, .rxBufferFullFlag, .parityError, .framingError,
    .overrunError, .breakDetect, .txIrq, .rxIrq);
  serial_peer_model peer (.sys_clk, .lineIn(txPin), .bitClks,
    .lineOut(rxPin), .ctsPinN);
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand
  function automatic int frame_len(data_len_t dl, parity_t pm);
    int w;
    w = (dl == LEN_7) ? 7 : (dl == LEN_8) ? 8 : 9;
    return w + ((pm != PAR_NONE && dl != LEN_9) ? 1 : 0);
  endfunction : frame_len
  function automatic logic [9:0] frame_bits(logic [7:0] d, logic n9,
                                            data_len_t dl, parity_t pm);
    logic [9:0] f;
    logic [7:0] m;
    m = (dl == LEN_7) ? 8'h7f : 8'hff;
    f = {2'h0, d & m};
    if (dl == LEN_9)
      f[8] = n9;
    else if (pm != PAR_NONE)
      f[(dl == LEN_7) ? 7 : 8] = (^(d & m)) ^ (pm == PAR_ODD);
    return f;
  endfunction : frame_bits
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic set_baud(input logic [4:0] code, input logic [10:0] div);
    @(posedge sys_clk);
    baudPrescalerSelect <= 5'h00;
    @(posedge sys_clk);
    baudPrescalerSelect <= code;
    baudDivisor <= div;
    bitClks <= 8'(8 * (code + 1) * (div + 1));
  endtask : set_baud
  task automatic write_pair(input logic [7:0] d0, d1, input logic n0, n1);
    @(posedge sys_clk);
    {txWriteData, txNinth, txWrite} <= {d0, n0, 1'b1};
    @(posedge sys_clk);
    {txWriteData, txNinth} <= {d1, n1};
    @(posedge sys_clk);
    txWrite <= 1'b0;
  endtask : write_pair
  task automatic wait_full();
    for (int k = 0; k < 99 && rxValid !== 1'b1; k++)
      @(posedge sys_clk);
    #1;
    check(rxValid, 1'b1);
  endtask : wait_full
  task automatic read_rx();
    @(posedge sys_clk);
    rxRead <= 1'b1;
    @(posedge sys_clk);
    rxRead <= 1'b0;
    #1;
    check(rxBufferFullFlag, 1'b0);
  endtask : read_rx
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    fails++;
    stop_test();
  end
  initial begin
    {txWrite, txNinth, rxRead, twoStop, sendBreak, flowEnable, rstn} = '0;
    {sampleOverrideBit, txIntEnable, rxIntEnable, txWriteData} = '0;
    {baudDivisor, samplePositionReg, fails, samples_checked} = '0;
    {baudPrescalerSelect, bitClks, seed} = {5'h01, 8'h10, 32'h00000028};
    dataLen = LEN_8;
    parityMode = PAR_NONE;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    #1;
    check({txPin, txBufferEmptyFlag, rxBufferFullFlag}, 3'h6);
    $display("test reset done");
    for (int c = 0; c < 18; c++) begin
      r = next_rand();
      l = data_len_t'(c / 6);
      p = parity_t'((c / 2) % 3);
      n = frame_len(l, p);
      set_baud(5'(1 + c % 3), 11'(c % 2));
      dataLen <= l;
      parityMode <= p;
      twoStop <= 1'(c % 2);
      {txIntEnable, rxIntEnable, sampleOverrideBit} <= r[18:16];
      samplePositionReg <= {2'h1, r[21:20]};
      fork
        write_pair(r[7:0], r[15:8], r[24], r[25]);
        begin
          peer.recv(n, b0, ok0);
          peer.recv(n, b1, ok1);
        end
      join
      check(b0, frame_bits(r[7:0], r[24], l, p));
      check(b1, frame_bits(r[15:8], r[25], l, p));
      check({ok0, ok1, txHoldRead}, {2'h3, r[15:8]});
      repeat (3 * bitClks) @(posedge sys_clk);
      #1;
      check({txInProgressFlag, txBufferEmptyFlag}, 2'h1);
      f0 = frame_bits(r[7:0], r[24], l, p);
      pe = (c % 2 == 1) && p != PAR_NONE && l != LEN_9;
      fe = (c % 2 == 0) && l == LEN_7;
      f0[n - 1] = f0[n - 1] ^ pe;
      peer.send(f0, n, !fe, 1);
      wait_full();
      check(rxData, r[7:0] & ((l == LEN_7) ? 8'h7f : 8'hff));
      check({parityError, framingError}, {pe, fe});
      if (l == LEN_9)
        check(rxNinth, r[24]);
      read_rx();
      $display("test format %0d done", c);
    end
    peer.send(frame_bits(r[7:0], 1'b1, l, p), n, 1'b1, 1);
    peer.send(frame_bits(r[15:8], 1'b0, l, p), n, 1'b1, 1);
    repeat (bitClks) @(posedge sys_clk);
    wait_full();
    check({overrunError, rxData}, {1'b1, r[15:8]});
    read_rx();
    $display("test overrun done");
    @(posedge sys_clk);
    sendBreak <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check(txPin, 1'b0);
    @(posedge sys_clk);
    sendBreak <= 1'b0;
    peer.send(10'h000, 10, 1'b0, 10);
    #1;
    check(breakDetect, 1'b1);
    $display("test break done");
    @(posedge sys_clk);
    flowEnable <= 1'b1;
    peer.set_cts(1'b1);
    repeat (4) @(posedge sys_clk);
    write_pair(r[7:0], r[15:8], 1'b0, 1'b1);
    repeat (64) @(posedge sys_clk);
    #1;
    check({txPin, rtsPinN}, 2'h2);
    fork
      peer.set_cts(1'b0);
      peer.recv(n, b0, ok0);
    join
    check(b0, frame_bits(r[7:0], 1'b0, l, p));
    $display("test flow control done");
    stop_test();
  end
endmodule : test_async_serial_transceiver
